// *** dosccs_osc_model.sv ***
// Purpose: behavioural pair of oscillators feeding the clock switch
// Assumes: run enables come from the block, waveforms are asynchronous to clk_i
// Notes:   the start delay ends half a nanosecond off a clk_i edge, so no edge meets clk_i
`timescale 1ns/100ps
module dosccs_osc_model #(
  parameter real MAIN_HALF = 21.0,
  parameter real SUB_HALF  = 81.0,
  parameter real START     = 401.5
) (
  input  wire logic main_run_i, // main oscillator run enable
  input  wire logic sub_run_i,  // sub oscillator run enable
  output logic      main_osc_o, // main oscillator waveform
  output logic      sub_osc_o   // sub oscillator waveform
);
  // ***************************
  // oscillators
  // ***************************
  // a stopped oscillator parks low and needs settling before
  // it swings again, so selecting it too early starves the cpu clock
  always
  begin
    main_osc_o = 1'b0;
    wait (main_run_i === 1'b1);
    #(START);
    while (main_run_i === 1'b1)
    begin
      #(MAIN_HALF);
      // a stop lets the current phase finish, then parks low without a glitch
      if (main_run_i === 1'b1)
        main_osc_o = ~main_osc_o;
    end
  end
  always
  begin
    sub_osc_o = 1'b0;
    wait (sub_run_i === 1'b1);
    #(START);
    while (sub_run_i === 1'b1)
    begin
      #(SUB_HALF);
      if (sub_run_i === 1'b1)
        sub_osc_o = ~sub_osc_o;
    end
  end
endmodule

// *** dosccs_pkg.sv ***
// Purpose: shared constants and types for the dual oscillator clock switch
// Assumes: classic Wishbone, 32-bit data, byte addresses
// Notes:   the control register holds eight bits in the low lane of the word
package dosccs_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [17:0] DOSCCS_CTRL_INDEX  = 18'h0FF02;
  localparam int          DOSCCS_ADR_W       = 20;
  localparam logic [7:0]  DOSCCS_CTRL_RESET  = 8'h0C;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int DOSCCS_BIT_RSV0   = 0;
  localparam int DOSCCS_BIT_RSV1   = 1;
  localparam int DOSCCS_BIT_OSC_EN = 2;
  localparam int DOSCCS_BIT_SEL    = 3;
  localparam int DOSCCS_WAIT_LSB   = 4;
  localparam int DOSCCS_BIT_RSV7   = 7;

  typedef struct packed {
    logic       reserved_bit_seven;
    logic [2:0] wait_state_field;
    logic       cpu_clock_select;
    logic       main_oscillator_en;
    logic       reserved_bit_one;
    logic       reserved_bit_zero;
  } dosccs_ctrl_s;

  typedef enum logic [1:0] {
    DOSCCS_RUN,
    DOSCCS_DRAIN,
    DOSCCS_ARM
  } dosccs_sw_e;

endpackage

// *** dosccs_top.sv ***
// Purpose: control and glitch-free selection of the cpu clock from two oscillators
// Assumes: oscillator outputs are slow next to clk_i and arrive asynchronously
// Notes:   the cpu clock is rebuilt in the clk_i domain, so edges are clk_i aligned
//
// Overview of operation
// - after reset the cpu clock comes from the main oscillator
// - bit two enables the main oscillator; reads return the stored value
// - the main oscillator enable bit resets to one
// - bit three selects main (1) or sub (0) oscillator for the cpu
// - the cpu clock select bit resets to one
// - main oscillator stops on sleep or when its enable is zero
// - sub oscillator stops on sleep
// - sub oscillator keeps feeding clock and stopwatch timers except while stopped by sleep
// - leaving standby resumes the clocking state held before it
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/100ps
module dosccs_top
  import dosccs_pkg::*;
(
  input  wire logic                    clk_i,            // 250 MHz system clock
  input  wire logic                    rst_i,            // synchronous reset, high
  input  wire logic                    cyc_i,            // wishbone cycle
  input  wire logic                    stb_i,            // wishbone strobe
  input  wire logic                    we_i,             // wishbone write
  input  wire logic [DOSCCS_ADR_W-1:0] adr_i,            // wishbone byte address
  input  wire logic [3:0]              sel_i,            // wishbone byte enables
  input  wire logic [31:0]             dat_i,            // wishbone write data
  output logic      [31:0]             dat_o,            // wishbone read data
  output logic                         ack_o,            // wishbone acknowledge
  input  wire logic                    sleep_instruction_i, // pulse: sleep executed
  input  wire logic                    wake_i,           // pulse: standby released
  input  wire logic                    main_oscillator_i, // main oscillator output
  input  wire logic                    sub_oscillator_i, // sub oscillator output
  output logic                         main_osc_run_o,   // main oscillator run enable
  output logic                         sub_osc_run_o,    // sub oscillator run enable
  output logic                         cpu_clk_o,        // selected cpu clock
  output logic                         timer_clk_o,      // clock and stopwatch timer source
  output logic      [2:0]              wait_state_o,     // wait-state field to bus unit
  output logic                         standby_o         // device in standby
);

  // ************************************************************
  // register and bus slave
  // ************************************************************
  dosccs_ctrl_s ctrl_q, ctrl_d;
  logic         ack_q, ack_d;
  logic [31:0]  dat_q, dat_d;
  logic         hit;

  assign hit = (adr_i[DOSCCS_ADR_W-1:2] == DOSCCS_CTRL_INDEX);

  always_comb
  begin
    ctrl_d = ctrl_q;
    ack_d  = 1'b0;
    dat_d  = dat_q;
    if (cyc_i && stb_i && !ack_q)
    begin
      ack_d = 1'b1;
      dat_d = 32'h00000000;
      if (hit)
        dat_d[7:0] = ctrl_q;
      if (hit && we_i && sel_i[0])
        ctrl_d = dosccs_ctrl_s'(dat_i[7:0]);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= dosccs_ctrl_s'(DOSCCS_CTRL_RESET);
      ack_q  <= 1'b0;
      dat_q  <= 32'h00000000;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      ack_q  <= ack_d;
      dat_q  <= dat_d;
    end
  end

  assign ack_o = ack_q;
  assign dat_o = dat_q;

  // ************************************************************
  // standby and oscillator enables
  // ************************************************************
  // register contents are untouched by standby, so wake resumes the old setup
  logic sleep_q, sleep_d;
  logic mrun_q, mrun_d;
  logic srun_q, srun_d;

  always_comb
  begin
    sleep_d = sleep_q;
    // wake returns to the prior state
    if (wake_i)
      sleep_d = 1'b0;
    else if (sleep_instruction_i)
      sleep_d = 1'b1;
    // main stops on sleep or enable low
    mrun_d = ctrl_d.main_oscillator_en && !sleep_d;
    srun_d = !sleep_d;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sleep_q <= 1'b0;
      mrun_q  <= 1'b1;
      srun_q  <= 1'b1;
    end
    else
    begin
      sleep_q <= sleep_d;
      mrun_q  <= mrun_d;
      srun_q  <= srun_d;
    end
  end

  assign main_osc_run_o = mrun_q;
  assign sub_osc_run_o  = srun_q;
  assign standby_o      = sleep_q;

  logic [2:0] wait_q;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wait_q <= 3'h0;
    else
      wait_q <= ctrl_d.wait_state_field;
  end
  assign wait_state_o = wait_q;

  // ************************************************************
  // oscillator input synchronisers
  // ************************************************************
  logic [2:0] msync_q, ssync_q;
  logic       mf_q, mf_d, sf_q, sf_d;

  always_comb
  begin
    mf_d = (msync_q[1] == msync_q[2]) ? msync_q[2] : mf_q;
    sf_d = (ssync_q[1] == ssync_q[2]) ? ssync_q[2] : sf_q;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      msync_q <= 3'h0;
      ssync_q <= 3'h0;
      mf_q    <= 1'b0;
      sf_q    <= 1'b0;
    end
    else
    begin
      msync_q <= {msync_q[1:0], main_oscillator_i};
      ssync_q <= {ssync_q[1:0], sub_oscillator_i};
      mf_q    <= mf_d;
      sf_q    <= sf_d;
    end
  end

  // ************************************************************
  // glitch-free source switch
  // ************************************************************
  // the old source is let finish its high phase, output parked low, and the
  // new source is only taken while it is low, so no pulse is ever shortened
  dosccs_sw_e st_q, st_d;
  logic       cur_q, cur_d;
  logic       cclk_q, cclk_d;
  logic       tclk_q, tclk_d;
  logic       src;

  assign src = cur_q ? mf_q : sf_q;

  always_comb
  begin
    st_d  = st_q;
    cur_d = cur_q;
    unique case (st_q)
      DOSCCS_RUN:
        if (ctrl_q.cpu_clock_select != cur_q && !src)
          st_d = DOSCCS_DRAIN;
      DOSCCS_DRAIN:
        st_d = DOSCCS_ARM;
      DOSCCS_ARM:
        // take new source only while low
        if (!(ctrl_q.cpu_clock_select ? mf_q : sf_q))
        begin
          cur_d = ctrl_q.cpu_clock_select;
          st_d  = DOSCCS_RUN;
        end
      // the fourth code of the state word is never entered
      default:
        st_d = DOSCCS_RUN;
    endcase
    cclk_d = (st_d == DOSCCS_RUN) ? (cur_d ? mf_q : sf_q) : 1'b0;
    // timers always fed from sub oscillator
    tclk_d = sf_q;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q   <= DOSCCS_RUN;
      cur_q  <= 1'b1;
      cclk_q <= 1'b0;
      tclk_q <= 1'b0;
    end
    else
    begin
      st_q   <= st_d;
      cur_q  <= cur_d;
      cclk_q <= cclk_d;
      tclk_q <= tclk_d;
    end
  end

  assign cpu_clk_o   = cclk_q;
  assign timer_clk_o = tclk_q;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic wr_take;
  assign wr_take = cyc_i && stb_i && !ack_q && we_i && hit && sel_i[0];

  sequence s_wr_ctrl;
    cyc_i && stb_i && !ack_q && we_i && hit && sel_i[0];
  endsequence

  a_reset_main_sel: assert property ($past(rst_i) |-> cur_q && ctrl_q.cpu_clock_select)
    else $error("cpu clock not on main oscillator after reset");
  a_enable_write: assert property (s_wr_ctrl |=> ctrl_q.main_oscillator_en == $past(dat_i[2]))
    else $error("enable bit did not take written value");
  a_reset_enable: assert property ($past(rst_i) |-> ctrl_q.main_oscillator_en && mrun_q)
    else $error("main oscillator not running after reset");
  a_select_write: assert property (s_wr_ctrl |=> ctrl_q.cpu_clock_select == $past(dat_i[3]))
    else $error("select bit did not take written value");
  a_reset_select: assert property ($past(rst_i) |-> ctrl_q.cpu_clock_select)
    else $error("select bit not set after reset");
  a_main_stop: assert property ((sleep_q || !ctrl_q.main_oscillator_en) |-> !mrun_q)
    else $error("main oscillator runs while stopped");
  a_sub_stop: assert property (sleep_instruction_i && !wake_i |=> !srun_q && sleep_q)
    else $error("sub oscillator not stopped by sleep");
  a_timer_feed: assert property (##1 timer_clk_o == $past(sf_q))
    else $error("timer clock not following sub oscillator");
  a_wake_keep: assert property (wake_i && !wr_take |=> $stable(ctrl_q))
    else $error("control state changed across standby exit");
  a_no_glitch: assert property ($rose(cpu_clk_o) |=> cpu_clk_o || !$past(src))
    else $error("cpu clock high pulse truncated");
  a_switch_time: assert property (st_q == DOSCCS_DRAIN |=> st_q == DOSCCS_ARM && !cpu_clk_o)
    else $error("switch did not park the clock low");

endmodule

// *** test_dosccs_top.sv ***
// Purpose: self-checking bench for the dual oscillator clock switch
// Assumes: one-cycle registered wishbone ack, oscillator model on the far side
// Notes:   read data expectations queue up and are matched when ack arrives
`timescale 1ns/100ps
module test_dosccs_top;
  import dosccs_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [DOSCCS_ADR_W-1:0] adr_i = '0;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = '0, dat_o;
  logic ack_o, sleep_instruction_i = 1'b0, wake_i = 1'b0, main_oscillator_i, sub_oscillator_i;
  logic main_osc_run_o, sub_osc_run_o, cpu_clk_o, timer_clk_o, standby_o, cpu_p, tim_p;
  logic [2:0] wait_state_o;
  logic [31:0] exp_q[$];
  logic [7:0] d;
  int errors = 0, checks_done = 0, cpu_rise = 0, tim_rise = 0, hi_n = 0, c, t;
  int seed = 32'h8250;
  localparam logic [19:0] CTRL_ADR = {DOSCCS_CTRL_INDEX, 2'b00};
  always #2 clk_i = ~clk_i;
  dosccs_top dosccs_top_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .sleep_instruction_i(sleep_instruction_i), .wake_i(wake_i),
    .main_oscillator_i(main_oscillator_i), .sub_oscillator_i(sub_oscillator_i),
    .main_osc_run_o(main_osc_run_o), .sub_osc_run_o(sub_osc_run_o), .cpu_clk_o(cpu_clk_o),
    .timer_clk_o(timer_clk_o), .wait_state_o(wait_state_o), .standby_o(standby_o));
  dosccs_osc_model dosccs_osc_model_i (.main_run_i(main_osc_run_o), .sub_run_i(sub_osc_run_o),
    .main_osc_o(main_oscillator_i), .sub_osc_o(sub_oscillator_i));
  // ***************************
  // shared tasks
  // ***************************
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("errors %0d checks_done %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [19:0] a, input logic [7:0] v,
                    input logic [3:0] s, input logic [7:0] e);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= {24'h0, v};
    if (!w)
      exp_q.push_back({24'h0, e});
    // request stands until ack is sampled high; only the watchdog ends a hung wait
    do @(posedge clk_i); while (ack_o !== 1'b1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask
  task automatic rate(input int n);
    int c0, t0;
    c0 = cpu_rise;
    t0 = tim_rise;
    repeat (n) @(posedge clk_i);
    c = cpu_rise - c0;
    t = tim_rise - t0;
  endtask
  task automatic standby(input logic main_exp);
    @(posedge clk_i) sleep_instruction_i <= 1'b1;
    @(posedge clk_i) sleep_instruction_i <= 1'b0;
    @(posedge clk_i);
    check("standby", standby_o, 1'b1);
    check("main run asleep", main_osc_run_o, 1'b0);
    check("sub run asleep", sub_osc_run_o, 1'b0);
    rate(40);
    rate(400);
    check("cpu stalled asleep", c, 0);
    check("timer stalled asleep", t, 0);
    @(posedge clk_i) wake_i <= 1'b1;
    @(posedge clk_i) wake_i <= 1'b0;
    @(posedge clk_i);
    check("standby left", standby_o, 1'b0);
    check("main run woken", main_osc_run_o, main_exp);
    check("sub run woken", sub_osc_run_o, 1'b1);
  endtask
  // ***************************
  // monitors
  // ***************************
  always @(posedge clk_i)
  begin
    if (ack_o === 1'b1 && we_i === 1'b0)
      check("read data", dat_o, exp_q.pop_front());
    if (cpu_clk_o === 1'b1 && cpu_p === 1'b0) cpu_rise++;
    if (timer_clk_o === 1'b1 && tim_p === 1'b0) tim_rise++;
    if (cpu_clk_o === 1'b1) hi_n++;
    else if (hi_n != 0)
    begin
      check("cpu high width", 32'(hi_n >= 4), 32'h1);
      hi_n = 0;
    end
    cpu_p = cpu_clk_o;
    tim_p = timer_clk_o;
  end
  initial
  begin
    repeat (20000) @(posedge clk_i);
    errors++;
    summarize();
  end
  // ***************************
  // main sequence
  // ***************************
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    check("main run reset", main_osc_run_o, 1'b1);
    wb(1'b0, CTRL_ADR, 8'h00, 4'hF, DOSCCS_CTRL_RESET);
    rate(200);
    rate(400);
    check("cpu on main", 32'(c > 25), 32'h1);
    check("timer runs", 32'(t > 5), 32'h1);
    repeat (6)
    begin
      d = 8'($random(seed)) | 8'h0C;
      wb(1'b1, CTRL_ADR, d, 4'hF, 8'h00);
      wb(1'b1, CTRL_ADR, ~d, 4'hE, 8'h00);
      wb(1'b1, 20'h00010, ~d, 4'hF, 8'h00);
      wb(1'b0, 20'h00010, 8'h00, 4'hF, 8'h00);
      wb(1'b0, CTRL_ADR, 8'h00, 4'hF, d);
      check("wait field", wait_state_o, d[6:4]);
    end
    standby(1'b1);
    // the sub oscillator restarts on wake and must settle before it is selected
    rate(150);
    wb(1'b1, CTRL_ADR, 8'h04, 4'hF, 8'h00);
    rate(300);
    wb(1'b1, CTRL_ADR, 8'h00, 4'hF, 8'h00);
    check("main stopped", main_osc_run_o, 1'b0);
    rate(400);
    check("cpu on sub", 32'(c > 4 && c < 16), 32'h1);
    check("timer on sub", 32'(t > 4), 32'h1);
    standby(1'b0);
    wb(1'b0, CTRL_ADR, 8'h00, 4'hF, 8'h00);
    wb(1'b1, CTRL_ADR, 8'h04, 4'hF, 8'h00);
    check("main restarted", main_osc_run_o, 1'b1);
    rate(300);
    wb(1'b1, CTRL_ADR, 8'h0C, 4'hF, 8'h00);
    rate(100);
    rate(400);
    check("cpu back on main", 32'(c > 25), 32'h1);
    summarize();
  end
endmodule
